// [lpms_defines.svh]
// timing counts and field layout for the low-power mode sequencer
`ifndef LPMS_DEFINES_SVH
`define LPMS_DEFINES_SVH
`define LPMS_QUAL_W 6
`define LPMS_QUAL_BASE 2
`define LPMS_QUAL_MIN_RAW 3
`define LPMS_FLUSH_CYCLES 32
`define LPMS_CLKOUT_MAX_CYCLES 45
`define LPMS_PLL_LOCK_CYCLES 131072
`define LPMS_OSC_SETTLE_CYCLES 64
`define LPMS_RESUME_FLASH_ACT 100
`define LPMS_RESUME_FLASH_SLP 1125
`define LPMS_RESUME_SRAM_STBY 100
`define LPMS_RESUME_SRAM_HALT 35
`define LPMS_CNT_W 18
`endif

// [lpms_pkg.sv]
// types for the low-power mode sequencer
package lpms_pkg;
    typedef enum logic [8:0] {
        LPMS_RUN = 9'h001,
        LPMS_FLUSH = 9'h002,
        LPMS_STBY = 9'h004,
        LPMS_HALT = 9'h008,
        LPMS_OSC_WAIT = 9'h010,
        LPMS_PLL_LOCK = 9'h020,
        LPMS_RESUME = 9'h040,
        LPMS_QUAL = 9'h080,
        LPMS_WAKE_HOLD = 9'h100
    } lpms_state_t;
endpackage

// [lpms_sequencer.sv]
// low-power mode sequencer: light sleep and deep sleep entry and exit
`timescale 1ns/100ps
`include "lpms_defines.svh"

module lpms_sequencer #(
    parameter int PLL_LOCK_CYCLES = `LPMS_PLL_LOCK_CYCLES,
    parameter int OSC_SETTLE_CYCLES = `LPMS_OSC_SETTLE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // cpu side
    input wire logic sleep_instr,
    input wire logic deep_sleep_sel,
    input wire logic [`LPMS_QUAL_W-1:0] wake_qual_count,
    input wire logic qual_enable,
    input wire logic flash_sleeps,
    input wire logic run_from_sram,
    input wire logic crystal_source,
    input wire logic wake_int_enable,
    output logic cpu_resume,
    output logic wake_int_req,
    // pins
    input wire logic wake_pin_n,
    // clock controls
    output logic clock_out_pin,
    output logic system_clock_en,
    output logic periph_clk_en,
    output logic pll_en,
    output logic watchdog_en,
    output logic osc_en,
    output logic int_osc_en,
    output logic core_clock_feed_en,
    output logic deep_sleep_active
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // counts must fit the shared counter
    if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES >= (1 << `LPMS_CNT_W))
    begin
        $error("pll lock count out of range");
    end
    if (OSC_SETTLE_CYCLES < 1 || OSC_SETTLE_CYCLES >= (1 << `LPMS_CNT_W))
    begin
        $error("osc settle count out of range");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [`LPMS_CNT_W-1:0] resume_limit(
        input logic deep, input logic fl_slp, input logic sram);
        logic [`LPMS_CNT_W-1:0] r;
        r = `LPMS_CNT_W'(`LPMS_RESUME_FLASH_ACT);
        if (sram)
            r = deep ? `LPMS_CNT_W'(`LPMS_RESUME_SRAM_HALT)
                     : `LPMS_CNT_W'(`LPMS_RESUME_SRAM_STBY);
        else if (fl_slp)
            r = `LPMS_CNT_W'(`LPMS_RESUME_FLASH_SLP);
        return r;
    endfunction

    lpms_pkg::lpms_state_t state;
    logic [`LPMS_CNT_W-1:0] cnt;
    logic in_deep;
    logic wake_prev;
    logic [`LPMS_QUAL_W:0] qual_target;

    // wake needs 3 raw cycles, or 2+count when qualified
    assign qual_target = qual_enable
        ? (`LPMS_QUAL_W+1)'(`LPMS_QUAL_BASE) + {1'b0, wake_qual_count}
        : (`LPMS_QUAL_W+1)'(`LPMS_QUAL_MIN_RAW);

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= lpms_pkg::LPMS_RUN;
            cnt <= '0;
            in_deep <= 1'b0;
        end
        else
        begin
            case (state)
                lpms_pkg::LPMS_RUN:
                begin
                    cnt <= '0;
                    if (sleep_instr)
                    begin
                        in_deep <= deep_sleep_sel;
                        state <= lpms_pkg::LPMS_FLUSH;
                    end
                end
                lpms_pkg::LPMS_FLUSH:
                begin
                    // clock held so the pipe drains before gating
                    cnt <= cnt + 1'b1;
                    if (cnt == `LPMS_CNT_W'(`LPMS_FLUSH_CYCLES - 1))
                    begin
                        cnt <= '0;
                        state <= in_deep ? lpms_pkg::LPMS_HALT
                                         : lpms_pkg::LPMS_STBY;
                    end
                end
                lpms_pkg::LPMS_STBY:
                begin
                    cnt <= '0;
                    if (!wake_pin_n)
                        state <= lpms_pkg::LPMS_QUAL;
                end
                lpms_pkg::LPMS_QUAL:
                begin
                    // consecutive cycles only; a gap restarts
                    if (wake_pin_n)
                        state <= lpms_pkg::LPMS_STBY;
                    else if (cnt + 1'b1 >= `LPMS_CNT_W'(qual_target - 1'b1))
                    begin
                        cnt <= '0;
                        state <= lpms_pkg::LPMS_RESUME;
                    end
                    else
                        cnt <= cnt + 1'b1;
                end
                lpms_pkg::LPMS_HALT:
                begin
                    cnt <= '0;
                    if (!wake_pin_n && wake_prev)
                        state <= lpms_pkg::LPMS_OSC_WAIT;
                end
                lpms_pkg::LPMS_OSC_WAIT:
                begin
                    if (cnt < `LPMS_CNT_W'(OSC_SETTLE_CYCLES))
                        cnt <= cnt + 1'b1;
                    // lock starts only when the pin is released
                    if (wake_pin_n)
                    begin
                        cnt <= '0;
                        state <= lpms_pkg::LPMS_PLL_LOCK;
                    end
                end
                lpms_pkg::LPMS_PLL_LOCK:
                begin
                    cnt <= cnt + 1'b1;
                    if (cnt == `LPMS_CNT_W'(PLL_LOCK_CYCLES - 1))
                    begin
                        cnt <= '0;
                        state <= lpms_pkg::LPMS_RESUME;
                    end
                end
                lpms_pkg::LPMS_RESUME:
                begin
                    // latency per mode from resume_limit: sram, flash asleep or flash active
                    cnt <= cnt + 1'b1;
                    if (cnt == resume_limit(in_deep, flash_sleeps,
                                            run_from_sram) - 2'd2)
                    begin
                        cnt <= '0;
                        state <= lpms_pkg::LPMS_WAKE_HOLD;
                    end
                end
                lpms_pkg::LPMS_WAKE_HOLD:
                begin
                    in_deep <= 1'b0;
                    state <= lpms_pkg::LPMS_RUN;
                end
                default:
                    state <= lpms_pkg::LPMS_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            wake_prev <= 1'b1;
        else
            wake_prev <= wake_pin_n;
    end

    // ------------------------------------------------------------
    // clock gating outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            clock_out_pin <= 1'b1;
            system_clock_en <= 1'b1;
            periph_clk_en <= 1'b1;
            pll_en <= 1'b1;
            watchdog_en <= 1'b1;
            osc_en <= 1'b1;
            int_osc_en <= 1'b1;
            core_clock_feed_en <= 1'b1;
            deep_sleep_active <= 1'b0;
        end
        else
        begin
            case (state)
                lpms_pkg::LPMS_STBY, lpms_pkg::LPMS_QUAL:
                begin
                    // clock out drops 33 cycles after the sleep op
                    clock_out_pin <= 1'b0;
                    system_clock_en <= 1'b0;
                    periph_clk_en <= 1'b0;
                    pll_en <= 1'b1;
                    watchdog_en <= 1'b1;
                end
                lpms_pkg::LPMS_HALT:
                begin
                    clock_out_pin <= 1'b0;
                    system_clock_en <= 1'b0;
                    periph_clk_en <= 1'b0;
                    pll_en <= 1'b0;
                    osc_en <= 1'b0;
                    int_osc_en <= !crystal_source;
                    core_clock_feed_en <= 1'b0;
                    deep_sleep_active <= 1'b1;
                end
                lpms_pkg::LPMS_OSC_WAIT:
                begin
                    osc_en <= 1'b1;
                    int_osc_en <= 1'b1;
                end
                lpms_pkg::LPMS_PLL_LOCK:
                    pll_en <= 1'b1;
                lpms_pkg::LPMS_RESUME:
                begin
                    clock_out_pin <= 1'b1;
                    system_clock_en <= 1'b1;
                    periph_clk_en <= 1'b1;
                    pll_en <= 1'b1;
                    osc_en <= 1'b1;
                    int_osc_en <= 1'b1;
                    core_clock_feed_en <= 1'b1;
                end
                lpms_pkg::LPMS_RUN:
                    deep_sleep_active <= 1'b0;
                default:
                    deep_sleep_active <= deep_sleep_active;
            endcase
        end
    end

    // ------------------------------------------------------------
    // resume and wake interrupt
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cpu_resume <= 1'b0;
            wake_int_req <= 1'b0;
        end
        else
        begin
            // pulse marks start of the instruction after sleep
            cpu_resume <= (state == lpms_pkg::LPMS_WAKE_HOLD);
            wake_int_req <= (state == lpms_pkg::LPMS_WAKE_HOLD)
                && wake_int_enable;
        end
    end
endmodule

// [lpms_sequencer_sva.sv]
// port checker for the low-power mode sequencer
`timescale 1ns/100ps
module lpms_seq_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // watched inputs
    input wire logic sleep_instr,
    input wire logic crystal_source,
    input wire logic wake_int_enable,
    input wire logic wake_pin_n,
    // watched outputs
    input wire logic cpu_resume,
    input wire logic wake_int_req,
    input wire logic clock_out_pin,
    input wire logic system_clock_en,
    input wire logic periph_clk_en,
    input wire logic pll_en,
    input wire logic watchdog_en,
    input wire logic osc_en,
    input wire logic int_osc_en,
    input wire logic core_clock_feed_en
);
    // ----------------
    // assertions
    // ----------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    clkout_delay_a: assert property (
        sleep_instr && clock_out_pin && system_clock_en
        |-> ##33 clock_out_pin ##1 !clock_out_pin)
        else $error("clock out not low 33 cycles after sleep");
    gate_together_a: assert property (
        $fell(clock_out_pin) |-> !system_clock_en && !periph_clk_en)
        else $error("system clock still on at clock out low");
    light_keep_a: assert property (
        $fell(periph_clk_en) && osc_en |-> pll_en && watchdog_en)
        else $error("pll or watchdog stopped in light sleep");
    deep_stop_a: assert property (
        $fell(pll_en) |-> !osc_en && !core_clock_feed_en
        && !periph_clk_en && !system_clock_en)
        else $error("deep sleep entry left a clock running");
    xtal_off_a: assert property (
        !pll_en && !osc_en && $stable(pll_en)
        |-> int_osc_en == !crystal_source)
        else $error("internal oscillator wrong in deep sleep");
    osc_start_a: assert property (
        !osc_en && $fell(wake_pin_n) |-> ##[1:2] osc_en)
        else $error("oscillator not started by wake pin fall");
    int_pair_a: assert property (
        wake_int_req == (cpu_resume && $past(wake_int_enable)))
        else $error("wake interrupt request not paired to resume");
    resume_pulse_a: assert property (
        cpu_resume |=> !cpu_resume)
        else $error("resume pulse longer than one cycle");
    clocks_back_a: assert property (
        cpu_resume |-> system_clock_en && core_clock_feed_en
        && pll_en && periph_clk_en && clock_out_pin)
        else $error("resume with clocks still gated");
endmodule
bind lpms_sequencer lpms_seq_chk u_chk (.core_clk, .rstn, .sleep_instr,
    .crystal_source, .wake_int_enable, .wake_pin_n, .cpu_resume,
    .wake_int_req, .clock_out_pin, .system_clock_en, .periph_clk_en,
    .pll_en, .watchdog_en, .osc_en, .int_osc_en, .core_clock_feed_en);

// [lpms_wake_src.sv]
// wake source model: holds the active low wake pin for a set count
`timescale 1ns/100ps
module lpms_wake_src (
    // clock
    input wire logic core_clk,
    // request from the bench
    input wire logic go,
    input wire logic [15:0] len,
    // wake pin
    output logic wake_pin_n
);
    logic [15:0] left = 16'h0000;
    // pulled up once released; caller sizes count past osc settle
    assign wake_pin_n = (left == 16'h0000);
    always_ff @(posedge core_clk)
    begin
        if (go)
            left <= len;
        else if (left != 16'h0000)
            left <= left - 16'h0001;
    end
endmodule

// [tb_top.sv]
// self-checking bench for the low-power mode sequencer
`timescale 1ns/100ps
`include "lpms_defines.svh"
module tb_top;
    localparam int LOCK = 16;
    logic core_clk = 1'h0, rstn = 1'h0, sleep_instr = 1'h0, go = 1'h0;
    logic deep_sleep_sel = 1'h0, qual_enable = 1'h0, flash_sleeps = 1'h0;
    logic run_from_sram = 1'h0, crystal_source = 1'h0;
    logic wake_int_enable = 1'h0;
    logic [5:0] wake_qual_count = 6'h00;
    logic [15:0] len = 16'h0000;
    logic cpu_resume, wake_int_req, clock_out_pin, system_clock_en;
    logic periph_clk_en, pll_en, watchdog_en, osc_en, int_osc_en;
    logic core_clock_feed_en, deep_sleep_active, wake_pin_n;
    logic [31:0] seed = 32'hbe1d_549b;
    logic [31:0] r;
    int bad_count = 0, cmp_count = 0, n, l, t;
    wire [9:0] st = {clock_out_pin, system_clock_en, periph_clk_en, pll_en,
        watchdog_en, osc_en, int_osc_en, core_clock_feed_en,
        deep_sleep_active, cpu_resume};
    always #2.5 core_clk = ~core_clk;
    lpms_wake_src u_src (.core_clk, .go, .len, .wake_pin_n);
    lpms_sequencer #(.PLL_LOCK_CYCLES(LOCK)) DUT (.core_clk, .rstn,
        .sleep_instr, .deep_sleep_sel, .wake_qual_count, .qual_enable,
        .flash_sleeps, .run_from_sram, .crystal_source, .wake_int_enable,
        .cpu_resume, .wake_int_req, .wake_pin_n, .clock_out_pin,
        .system_clock_en, .periph_clk_en, .pll_en, .watchdog_en, .osc_en,
        .int_osc_en, .core_clock_feed_en, .deep_sleep_active);
    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int lat(input logic fs, input logic sr, input logic dp);
        if (sr)
            return dp ? `LPMS_RESUME_SRAM_HALT : `LPMS_RESUME_SRAM_STBY;
        return fs ? `LPMS_RESUME_FLASH_SLP : `LPMS_RESUME_FLASH_ACT;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // hold the pin low k edges; edge counting starts after return
    task automatic pulse(input int k);
        @(posedge core_clk);
        go <= 1'h1;
        len <= 16'(k);
        @(posedge core_clk);
        go <= 1'h0;
        #1;
    endtask
    task automatic wait_resume(input int lim, output int k);
        k = 0;
        while (cpu_resume !== 1'h1)
        begin
            if (k == lim)
            begin
                chk("resume_timeout", 0, 1);
                tally_and_finish();
            end
            tick(1);
            k++;
        end
    endtask
    task automatic enter();
        @(posedge core_clk);
        {wake_int_enable, crystal_source, run_from_sram} <= r[11:9];
        {flash_sleeps, wake_qual_count, qual_enable} <= r[8:1];
        deep_sleep_sel <= r[0];
        sleep_instr <= 1'h1;
        @(posedge core_clk);
        sleep_instr <= 1'h0;
        tick(32);
        chk("clock_early", 1, clock_out_pin);
        tick(1);
        chk("clock_out", 0, clock_out_pin);
        chk("sys_clk", 0, system_clock_en);
        chk("osc", !r[0], osc_en);
        chk("watchdog", 1, watchdog_en);
        chk("deep_flag", r[0], deep_sleep_active);
        chk("periph", 0, periph_clk_en);
        chk("pll", !r[0], pll_en);
        chk("feed", !r[0], core_clock_feed_en);
        tick(2);
        chk("int_osc", !(r[0] && r[10]), int_osc_en);
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'h1;
        tick(1);
        chk("reset_state", 10'h3fc, st);
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            r = seed;
            if (i < 2)
                r[7:0] = i ? 8'h02 : 8'hfe;
            if (i == 2)
                r[9:0] = 10'h201;
            if (i == 3)
                r[9:0] = 10'h101;
            enter();
            n = r[1] ? 2 + r[7:2] : 3;
            l = lat(r[8], r[9], r[0]);
            if (r[0])
            begin
                pulse(`LPMS_OSC_SETTLE_CYCLES + 6);
                tick(2);
                chk("osc_on", 1, osc_en);
                // pin seen high settle+5 edges on; lock must still run
                tick(`LPMS_OSC_SETTLE_CYCLES + 5 + LOCK);
                chk("lock_feed", 0, core_clock_feed_en);
                chk("lock_pll", 1, pll_en);
                wait_resume(4000, t);
                chk("halt_lat", 1, t >= 1 && t <= l);
            end
            else
            begin
                pulse(n - 1);
                tick(n + 6);
                chk("glitch", 0, system_clock_en);
                pulse(n);
                wait_resume(2000, t);
                chk("stby_lat", 1, t >= n && t <= n + l + 3);
            end
            chk("resume_state", {8'hff, r[0], 1'h1}, st);
            chk("int_req", r[11], wake_int_req);
            tick(1);
            $display("test %0d done", i);
        end
        r = 32'h0000_0001;
        enter();
        @(posedge core_clk);
        rstn <= 1'h0;
        tick(`LPMS_OSC_SETTLE_CYCLES + 8);
        chk("reset_mid", 10'h3fc, st);
        @(posedge core_clk);
        rstn <= 1'h1;
        tick(2);
        chk("reset_after", 10'h3fc, st);
        // light sleep right after the mid-run reset must still work
        r = 32'h0000_0000;
        enter();
        pulse(3);
        wait_resume(2000, t);
        chk("post_reset", 1, t == 3 + `LPMS_RESUME_FLASH_ACT);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
